// ===== rtl/uart_status_data_baud_regs.sv
`timescale 1ns/1ps
module uart_status_data_baud_regs (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [31:0] rd_data_out,
    input  wire logic        rx_pin_in,
    input  wire logic        clear_to_send_low_in,
    output logic             tx_pin_out,
    output logic             irq_out
);
    baud_if bif ();
    logic [15:0] ctrl_a_r, ctrl_b_r, baud_r;
    logic [3:0]  ctrl_c_r;
    logic rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r, cts_prev_r;
    logic cts_flag_r, brk_flag_r, tx_empty_r, tx_done_r, rx_full_r;
    logic idle_r, ore_r, noise_r, frame_r, parity_r, seen_r;
    logic [8:0]  tx_buf_r, tx_sh_r, rx_sh_r, rx_data_r, rx_word;
    logic [3:0]  tx_tick_r, tx_bit_r, rx_tick_r, rx_bit_r, nbits;
    logic [1:0]  rx_smp_r;
    logic        rx_noise_r, idle_arm_r;
    logic [7:0]  idle_cnt_r;
    uart_pkg::line_state_e tx_state_r, rx_state_r;
    logic [31:0] status;
    logic wr_stat, wr_data, rd_stat, rd_data, seq_clr;
    logic en, len9, par_on, odd, tick, tx_load, tx_fin;
    logic maj, noisy, rx_smp, rx_done, stop_low, par_bad, idle_set;
    logic brk, cts_edge;
    logic [8:0] tx_word;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Bus decode and control fields
    assign wr_stat = wr_en_in && addr_in == uart_pkg::ADDR_STATUS;
    assign wr_data = wr_en_in && addr_in == uart_pkg::ADDR_DATA;
    assign rd_stat = rd_en_in && addr_in == uart_pkg::ADDR_STATUS;
    assign rd_data = rd_en_in && addr_in == uart_pkg::ADDR_DATA;
    assign seq_clr = rd_data && seen_r;
    assign en     = ctrl_a_r[uart_pkg::CA_EN];
    assign len9   = ctrl_a_r[uart_pkg::CA_LEN9];
    assign par_on = ctrl_a_r[uart_pkg::CA_PAR_EN];
    assign odd    = ctrl_a_r[uart_pkg::CA_PAR_ODD];
    assign nbits  = len9 ? uart_pkg::BITS_9 : uart_pkg::BITS_8;
    assign tick   = bif.tick;
    assign bif.divisor = baud_r;
    assign bif.run     = en;
    baud_tick_gen u_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .bus      (bif)
    );
    // Parity takes the place of the top data bit
    always_comb
    begin
        tx_word = wr_data_in[8:0];
        if (par_on && len9)
            tx_word[8] = ^wr_data_in[7:0] ^ odd;
        else if (par_on)
            tx_word[7] = ^wr_data_in[6:0] ^ odd;
        if (!len9)
            tx_word[8] = 1'b0;
    end
    // Pins cross from outside: two flops before any use
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_s1_r    <= 1'b1;
            rx_s2_r    <= 1'b1;
            cts_s1_r   <= 1'b1;
            cts_s2_r   <= 1'b1;
            cts_prev_r <= 1'b1;
        end
        else
        begin
            rx_s1_r    <= rx_pin_in;
            rx_s2_r    <= rx_s1_r;
            cts_s1_r   <= clear_to_send_low_in;
            cts_s2_r   <= cts_s1_r;
            cts_prev_r <= cts_s2_r;
        end
    end
    assign cts_edge = ctrl_c_r[uart_pkg::CC_FLOW] && cts_s2_r != cts_prev_r;
    // Software registers; reserved bits are masked away
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_a_r <= 16'h0000;
            ctrl_b_r <= 16'h0000;
            ctrl_c_r <= 4'h0;
            baud_r   <= 16'h0000;
            tx_buf_r <= 9'h000;
        end
        else if (wr_en_in)
        begin
            case (addr_in)
                uart_pkg::ADDR_CTRL_A: ctrl_a_r <= wr_data_in[15:0]
                                                 & uart_pkg::CA_MASK;
                uart_pkg::ADDR_CTRL_B: ctrl_b_r <= wr_data_in[15:0]
                                                 & uart_pkg::CB_MASK;
                uart_pkg::ADDR_CTRL_C: ctrl_c_r <= wr_data_in[3:0];
                uart_pkg::ADDR_BAUD:   baud_r   <= wr_data_in[15:0];
                uart_pkg::ADDR_DATA:   tx_buf_r <= tx_word;
                default:               ;
            endcase
        end
    end
    // Transmitter; with flow control a frame waits for clear-to-send
    assign tx_load = en && ctrl_a_r[uart_pkg::CA_TX_EN] && !tx_empty_r
        && tx_state_r == uart_pkg::LINE_IDLE
        && !(ctrl_c_r[uart_pkg::CC_FLOW] && cts_s2_r);
    assign tx_fin = tick && tx_tick_r == uart_pkg::TICK_LAST
        && tx_state_r == uart_pkg::LINE_STOP;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_state_r <= uart_pkg::LINE_IDLE;
            tx_sh_r    <= 9'h000;
            tx_tick_r  <= 4'h0;
            tx_bit_r   <= 4'h0;
            tx_pin_out <= 1'b1;
        end
        else if (!en)
        begin
            tx_state_r <= uart_pkg::LINE_IDLE;
            tx_pin_out <= 1'b1;
        end
        else
        begin
            tx_pin_out <= tx_state_r == uart_pkg::LINE_START ? 1'b0
                        : tx_state_r == uart_pkg::LINE_DATA  ? tx_sh_r[0]
                        : 1'b1;
            if (tx_load)
            begin
                tx_sh_r    <= tx_buf_r;
                tx_tick_r  <= 4'h0;
                tx_bit_r   <= 4'h0;
                tx_state_r <= uart_pkg::LINE_START;
            end
            else if (tick && tx_state_r != uart_pkg::LINE_IDLE)
            begin
                tx_tick_r <= tx_tick_r + 4'h1;
                if (tx_tick_r == uart_pkg::TICK_LAST)
                begin
                    case (tx_state_r)
                        uart_pkg::LINE_START:
                            tx_state_r <= uart_pkg::LINE_DATA;
                        uart_pkg::LINE_DATA:
                        begin
                            tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
                            tx_bit_r <= tx_bit_r + 4'h1;
                            if (tx_bit_r == nbits - 4'h1)
                                tx_state_r <= uart_pkg::LINE_STOP;
                        end
                        default:
                            tx_state_r <= uart_pkg::LINE_IDLE;
                    endcase
                end
            end
        end
    end
    // Receiver votes three samples mid-bit; disagreement means noise
    assign maj   = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[0] & rx_s2_r)
                 | (rx_smp_r[1] & rx_s2_r);
    assign noisy = !(rx_smp_r[0] == rx_s2_r && rx_smp_r[1] == rx_s2_r);
    assign rx_smp = tick && rx_tick_r == uart_pkg::TICK_V2;
    assign rx_done = rx_smp && rx_state_r == uart_pkg::LINE_STOP;
    assign stop_low = !maj;
    assign rx_word = len9 ? rx_sh_r : {1'b0, rx_sh_r[7:0]};
    assign par_bad = par_on && (^rx_word ^ odd);
    assign brk = ctrl_b_r[uart_pkg::CB_LIN_EN] && stop_low
        && rx_word == 9'h000;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_state_r <= uart_pkg::LINE_IDLE;
            rx_tick_r  <= 4'h0;
            rx_bit_r   <= 4'h0;
            rx_sh_r    <= 9'h000;
            rx_smp_r   <= 2'b11;
            rx_noise_r <= 1'b0;
        end
        else if (!en || !ctrl_a_r[uart_pkg::CA_RX_EN])
            rx_state_r <= uart_pkg::LINE_IDLE;
        else if (tick)
        begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == uart_pkg::TICK_V0)
                rx_smp_r[0] <= rx_s2_r;
            if (rx_tick_r == uart_pkg::TICK_V1)
                rx_smp_r[1] <= rx_s2_r;
            if (rx_smp && rx_state_r != uart_pkg::LINE_IDLE && noisy)
                rx_noise_r <= 1'b1;
            case (rx_state_r)
                uart_pkg::LINE_IDLE:
                    if (!rx_s2_r)
                    begin
                        rx_state_r <= uart_pkg::LINE_START;
                        rx_tick_r  <= 4'h1;
                        rx_bit_r   <= 4'h0;
                        rx_sh_r    <= 9'h000;
                        rx_noise_r <= 1'b0;
                    end
                uart_pkg::LINE_START:
                    if (rx_smp && maj)
                        rx_state_r <= uart_pkg::LINE_IDLE; // False start
                    else if (rx_tick_r == uart_pkg::TICK_LAST)
                        rx_state_r <= uart_pkg::LINE_DATA;
                uart_pkg::LINE_DATA:
                begin
                    if (rx_smp)
                        rx_sh_r[rx_bit_r] <= maj;
                    if (rx_tick_r == uart_pkg::TICK_LAST)
                    begin
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == nbits - 4'h1)
                            rx_state_r <= uart_pkg::LINE_STOP;
                    end
                end
                default:
                    if (rx_smp) // Back to hunting for the next start
                        rx_state_r <= uart_pkg::LINE_IDLE;
            endcase
        end
    end
    // Idle watch arms after a frame so a quiet line reports only once
    assign idle_set = idle_arm_r && tick && rx_state_r == uart_pkg::LINE_IDLE
        && rx_s2_r && idle_cnt_r == (len9 ? uart_pkg::IDLE_TICKS_9
                                          : uart_pkg::IDLE_TICKS_8) - 8'h01;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            idle_cnt_r <= 8'h00;
            idle_arm_r <= 1'b0;
        end
        else if (rx_done || rx_state_r != uart_pkg::LINE_IDLE || !rx_s2_r)
        begin
            idle_cnt_r <= 8'h00;
            idle_arm_r <= idle_arm_r || rx_done;
        end
        else if (idle_set)
            idle_arm_r <= 1'b0;
        else if (tick && idle_arm_r)
            idle_cnt_r <= idle_cnt_r + 8'h01;
    end
    // Status flags: a hardware set wins over a software clear, except tx empty, where a data write beats tx_load
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            {cts_flag_r, brk_flag_r, rx_full_r, idle_r} <= 4'h0;
            {ore_r, noise_r, frame_r, parity_r}         <= 4'h0;
            tx_empty_r <= uart_pkg::STATUS_RESET[uart_pkg::ST_TXE];
            tx_done_r  <= uart_pkg::STATUS_RESET[uart_pkg::ST_TXD];
            seen_r    <= 1'b0;
            rx_data_r <= 9'h000;
        end
        else
        begin
            cts_flag_r <= cts_edge || (cts_flag_r
                && !(wr_stat && !wr_data_in[uart_pkg::ST_CTS]));
            brk_flag_r <= (rx_done && brk) || (brk_flag_r
                && !(wr_stat && !wr_data_in[uart_pkg::ST_LIN]));
            // A new write is newer data than the one just loaded
            tx_empty_r <= !wr_data && (tx_empty_r || tx_load);
            tx_done_r <= (tx_fin && tx_empty_r) || (tx_done_r
                && !(wr_stat && !wr_data_in[uart_pkg::ST_TXD]));
            rx_full_r <= rx_done || (rx_full_r && !rd_data
                && !(wr_stat && !wr_data_in[uart_pkg::ST_RXF]));
            idle_r <= idle_set || (idle_r && !seq_clr);
            ore_r <= (rx_done && rx_full_r)
                || (ore_r && !seq_clr);
            noise_r <= (rx_done && (rx_noise_r || noisy))
                || (noise_r && !seq_clr);
            frame_r <= (rx_done && stop_low)
                || (frame_r && !seq_clr);
            parity_r <= (rx_done && par_bad)
                || (parity_r && !(seen_r && (rd_data || wr_data)));
            if (rx_done && !rx_full_r)
                rx_data_r <= rx_word;
            if (rd_stat)
                seen_r <= 1'b1;
            else if (rd_data || wr_data)
                seen_r <= 1'b0;
        end
    end
    assign status = {22'h000000, cts_flag_r, brk_flag_r, tx_empty_r,
                     tx_done_r, rx_full_r, idle_r, ore_r, noise_r, frame_r,
                     parity_r};
    // Read data stand for the one cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rd_data_out <= 32'h0000_0000;
        else if (rd_en_in)
        begin
            case (addr_in)
                uart_pkg::ADDR_STATUS: rd_data_out <= status;
                uart_pkg::ADDR_DATA:   rd_data_out <= {23'h000000, rx_data_r};
                uart_pkg::ADDR_BAUD:   rd_data_out <= {16'h0000, baud_r};
                uart_pkg::ADDR_CTRL_A: rd_data_out <= {16'h0000, ctrl_a_r};
                uart_pkg::ADDR_CTRL_B: rd_data_out <= {16'h0000, ctrl_b_r};
                uart_pkg::ADDR_CTRL_C: rd_data_out <= {28'h0000000, ctrl_c_r};
                default:               rd_data_out <= 32'h0000_0000;
            endcase
        end
        else
            rd_data_out <= 32'h0000_0000;
    end
    // One combined request; overrun moves to the error enable in DMA mode
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= (tx_empty_r && ctrl_a_r[uart_pkg::CA_TXE_IE])
                || (tx_done_r && ctrl_a_r[uart_pkg::CA_TXD_IE])
                || (rx_full_r && ctrl_a_r[uart_pkg::CA_RXF_IE])
                || (idle_r && ctrl_a_r[uart_pkg::CA_IDLE_IE])
                || (parity_r && ctrl_a_r[uart_pkg::CA_PAR_IE])
                || (brk_flag_r && ctrl_b_r[uart_pkg::CB_LIN_IE])
                || (cts_flag_r && ctrl_c_r[uart_pkg::CC_CTS_IE])
                || ((noise_r || frame_r)
                    && ctrl_c_r[uart_pkg::CC_ERR_IE])
                || (ore_r && (ctrl_c_r[uart_pkg::CC_MP_DMA]
                    ? ctrl_c_r[uart_pkg::CC_ERR_IE]
                    : ctrl_a_r[uart_pkg::CA_RXF_IE]));
    end
    rd_idle_zero_a: assert property (
        !rd_en_in |=> rd_data_out == 32'h0000_0000)
        else $error("read data not cleared outside a read");
    tx_empty_clr_a: assert property (
        wr_data |=> !tx_empty_r && tx_buf_r == $past(tx_word))
        else $error("tx empty flag not cleared by data write");
    tx_done_set_a: assert property (
        tx_fin && tx_empty_r |=> tx_done_r)
        else $error("tx done flag not set at frame end");
    rx_full_rd_a: assert property (
        rd_data && !rx_done |=> !rx_full_r)
        else $error("rx full flag survives data read");
    overrun_set_a: assert property (
        rx_done && rx_full_r |=> ore_r && $stable(rx_data_r))
        else $error("overrun not flagged or data overwritten");
    frame_err_a: assert property (
        rx_done && stop_low |=> frame_r ##1 (frame_r || $past(seq_clr)))
        else $error("framing flag missing");
    seq_clear_a: assert property (
        seen_r && rd_data && !rx_done && !idle_set
        |=> !(idle_r || ore_r || noise_r || frame_r))
        else $error("error flags not cleared by read sequence");
    parity_clr_a: assert property (
        seen_r && wr_data && !rx_done |=> !parity_r)
        else $error("parity flag not cleared");
    cts_flag_a: assert property (
        cts_edge |=> cts_flag_r ##1 (cts_flag_r || $past(wr_stat)))
        else $error("cts toggle not flagged");
    irq_ovr_a: assert property (
        ore_r && ctrl_c_r[uart_pkg::CC_MP_DMA]
        && ctrl_c_r[uart_pkg::CC_ERR_IE] |=> irq_out)
        else $error("overrun interrupt missing in DMA mode");
    baud_hold_a: assert property (
        wr_en_in && addr_in == uart_pkg::ADDR_BAUD
        |=> baud_r == $past(wr_data_in[15:0]))
        else $error("baud register did not take write");
endmodule : uart_status_data_baud_regs

// ===== rtl/uart_pkg.sv
package uart_pkg;
    // Byte addresses of the word registers
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_BAUD   = 8'h08;
    localparam logic [7:0] ADDR_CTRL_A = 8'h0C;
    localparam logic [7:0] ADDR_CTRL_B = 8'h10;
    localparam logic [7:0] ADDR_CTRL_C = 8'h14;
    // Status bit positions
    localparam int ST_CTS  = 9;
    localparam int ST_LIN  = 8;
    localparam int ST_TXE  = 7;
    localparam int ST_TXD  = 6;
    localparam int ST_RXF  = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_ORE  = 3;
    localparam int ST_NOISE = 2;
    localparam int ST_FRAME = 1;
    localparam int ST_PAR  = 0;
    localparam logic [31:0] STATUS_RESET = 32'h0000_00C0;
    // Control register A fields
    localparam int CA_EN      = 13;
    localparam int CA_LEN9    = 12;
    localparam int CA_PAR_EN  = 10;
    localparam int CA_PAR_ODD = 9;
    localparam int CA_PAR_IE  = 8;
    localparam int CA_TXE_IE  = 7;
    localparam int CA_TXD_IE  = 6;
    localparam int CA_RXF_IE  = 5;
    localparam int CA_IDLE_IE = 4;
    localparam int CA_TX_EN   = 3;
    localparam int CA_RX_EN   = 2;
    localparam logic [15:0] CA_MASK = 16'h37FC;
    // Control register B fields
    localparam int CB_LIN_EN = 14;
    localparam int CB_LIN_IE = 6;
    localparam logic [15:0] CB_MASK = 16'h4040;
    // Control register C fields
    localparam int CC_ERR_IE = 0;
    localparam int CC_MP_DMA = 1;
    localparam int CC_FLOW   = 2;
    localparam int CC_CTS_IE = 3;
    // Widths and oversampling
    localparam int DATA_W = 9;
    localparam int BAUD_W = 16;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_V0   = 4'h7;
    localparam logic [3:0] TICK_V1   = 4'h8;
    localparam logic [3:0] TICK_V2   = 4'h9;
    localparam logic [3:0] BITS_8    = 4'h8;
    localparam logic [3:0] BITS_9    = 4'h9;
    localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
    localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
    localparam logic [16:0] OVERSAMPLE = 17'h00010;
    typedef enum logic [1:0] {
        LINE_IDLE  = 2'b00,
        LINE_START = 2'b01,
        LINE_DATA  = 2'b11,
        LINE_STOP  = 2'b10
    } line_state_e;
endpackage : uart_pkg

// ===== rtl/baud_if.sv
`timescale 1ns/1ps
interface baud_if;
    logic [15:0] divisor;
    logic        run;
    logic        tick;
    modport regs (output divisor, output run, input tick);
    modport gen  (input divisor, input run, output tick);
endinterface : baud_if

// ===== rtl/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    baud_if.gen       bus
);
    logic [16:0] acc_r;
    logic [16:0] sum;
    logic [16:0] div;

    // Accumulator counts sixteenths of a clock against the divisor
    assign sum = acc_r + uart_pkg::OVERSAMPLE;
    assign div = {1'b0, bus.divisor};

    // Fractional divider; a divisor below one whole ticks every cycle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            acc_r    <= 17'h00000;
            bus.tick <= 1'b0;
        end
        else if (!bus.run)
        begin
            acc_r    <= 17'h00000;
            bus.tick <= 1'b0;
        end
        else if (div < uart_pkg::OVERSAMPLE)
        begin
            acc_r    <= 17'h00000;
            bus.tick <= 1'b1;
        end
        else if (sum >= div)
        begin
            acc_r    <= sum - div;
            bus.tick <= 1'b1;
        end
        else
        begin
            acc_r    <= sum;
            bus.tick <= 1'b0;
        end
    end
endmodule : baud_tick_gen

// ===== sim/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
    input  wire logic       clk_in,
    input  wire logic       tx_in,
    output logic            rx_out,
    output logic            got_out,
    output logic [7:0]      byte_out
);
    // Bit time matches a baud divider of 0x10, one tick a clock
    localparam int BIT = 16;
    initial
    begin
        rx_out = 1'b1;
        got_out = 1'b0;
        byte_out = 8'h00;
    end
    // One 8-bit frame; a low stop bit gives a framing fault
    task send(input logic [7:0] b, input logic stop);
        rx_out <= 1'b0;
        repeat (BIT) @(posedge clk_in);
        for (int i = 0; i < 8; i++)
        begin
            rx_out <= b[i];
            repeat (BIT) @(posedge clk_in);
        end
        rx_out <= stop;
        repeat (BIT) @(posedge clk_in);
        rx_out <= 1'b1; // Idle gap so frames never merge
        repeat (BIT) @(posedge clk_in);
    endtask : send
    // Capture device frames mid-bit, LSB first
    always
    begin
        @(negedge tx_in);
        repeat (BIT + BIT / 2) @(posedge clk_in);
        for (int k = 0; k < 8; k++)
        begin
            byte_out[k] <= tx_in;
            repeat (BIT) @(posedge clk_in);
        end
        got_out <= 1'b1;
        @(posedge clk_in);
        got_out <= 1'b0;
    end
endmodule : serial_peer

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0;
    logic cts_low = 0, rd_q = 0, irq_probe = 0, tx_pin_out, irq_out;
    logic rx_line, got;
    logic [7:0]  addr_in = 8'h00, got_byte;
    logic [31:0] wr_data_in = 32'h0, rnd, rd_data_out, exp_q[$], msk_q[$];
    integer seed = 59, miscompares = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    uart_status_data_baud_regs u_uart_status_data_baud_regs (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .rx_pin_in(rx_line),
        .clear_to_send_low_in(cts_low), .tx_pin_out(tx_pin_out),
        .irq_out(irq_out));
    serial_peer u_serial_peer (.clk_in(clk_in), .tx_in(tx_pin_out),
        .rx_out(rx_line), .got_out(got), .byte_out(got_byte));
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task finish_test;
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Oldest note against whichever result shows this cycle
    always @(posedge clk_in)
    begin
        rd_q <= rd_en_in;
        if (rd_q | got | irq_probe)
        begin
            chk((rd_q ? rd_data_out : got ? {24'h0, got_byte}
                 : {31'h0, irq_out}) & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    task put(input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back(v & m);
        msk_q.push_back(m);
    endtask : put
    // Every access is a full word
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        put(v, m);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
    endtask : rd
    // Irq is registered, so let two edges pass before looking
    task probe(input logic v);
        put({31'h0, v}, ALL);
        repeat (2) @(posedge clk_in);
        irq_probe <= 1'b1;
        @(posedge clk_in);
        irq_probe <= 1'b0;
    endtask : probe
    task rx_then_read(input logic [7:0] b, input logic stop);
        u_serial_peer.send(b, stop);
        repeat (250) @(posedge clk_in); // Lets the idle frame time run out
    endtask : rx_then_read
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00C0, ALL);
        rd(uart_pkg::ADDR_BAUD, 32'h0, ALL);
        rd(8'h20, 32'h0, ALL);
        wr(uart_pkg::ADDR_BAUD, 32'hFFFF_0010); // Port still off
        rd(uart_pkg::ADDR_BAUD, 32'h0000_0010, ALL);
        wr(uart_pkg::ADDR_CTRL_A, 32'h0000_200C);
        rnd = $random(seed);
        wr(uart_pkg::ADDR_DATA, rnd);
        wr(uart_pkg::ADDR_DATA, rnd >> 8);
        rd(uart_pkg::ADDR_STATUS, 32'h0, 32'h80);
        put({24'h0, rnd[7:0]}, ALL);
        put({24'h0, rnd[15:8]}, ALL);
        repeat (400) @(posedge clk_in);
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00C0, ALL);
        rx_then_read(8'h3C, 1'b1);
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00F0, ALL);
        rd(uart_pkg::ADDR_DATA, 32'h0000_003C, ALL);
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00C0, ALL);
        u_serial_peer.send(8'h11, 1'b1);
        rx_then_read(8'h22, 1'b1);
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00F8, ALL);
        rd(uart_pkg::ADDR_DATA, 32'h0000_0011, ALL);
        rd(uart_pkg::ADDR_STATUS, 32'h0000_00C0, ALL);
        rx_then_read(8'h55, 1'b0);
        rd(uart_pkg::ADDR_STATUS, 32'h2, 32'h2);
        rd(uart_pkg::ADDR_DATA, 32'h0000_0055, ALL);
        rd(uart_pkg::ADDR_STATUS, 32'h0, 32'h1F);
        wr(uart_pkg::ADDR_CTRL_A, 32'h0000_240C); // Even parity on
        rx_then_read(8'h01, 1'b1);
        rd(uart_pkg::ADDR_STATUS, 32'h1, 32'h1);
        rd(uart_pkg::ADDR_DATA, 32'h0000_0001, ALL);
        rd(uart_pkg::ADDR_STATUS, 32'h0, 32'h1);
        put(32'h0000_0081, ALL);
        wr(uart_pkg::ADDR_DATA, 32'h0000_0001);
        repeat (250) @(posedge clk_in);
        wr(uart_pkg::ADDR_CTRL_A, 32'h0000_208C);
        probe(1'b1);
        wr(uart_pkg::ADDR_CTRL_A, 32'h0000_200C);
        probe(1'b0);
        wr(uart_pkg::ADDR_CTRL_C, 32'h0000_0004);
        cts_low <= 1'b1;
        repeat (8) @(posedge clk_in);
        rd(uart_pkg::ADDR_STATUS, 32'h200, 32'h200);
        wr(uart_pkg::ADDR_STATUS, 32'h0);
        rd(uart_pkg::ADDR_STATUS, 32'h0, 32'h200);
        repeat (3) @(posedge clk_in);
        finish_test;
    end
    // Whole run is a few thousand cycles; this cuts a hang short
    initial
    begin
        #200000;
        miscompares++;
        finish_test;
    end
endmodule : testbench
